//--- pkg/ucsr_pkg.sv
// constants and carrier types for the user config space readout
package ucsr_pkg;
	localparam int          REQ_W      = 40;
	localparam logic [5:0]  AM_CRCSR   = 6'h2F;
	localparam logic [1:0]  LANE0      = 2'h3;
	// fixed cr pointer locations, three bytes each, big endian
	localparam logic [18:0] CR_BEG_ROM = 19'h000B3;
	localparam logic [18:0] CR_END_ROM = 19'h000BF;
	localparam logic [18:0] CR_BEG_CSR = 19'h000CB;
	localparam logic [18:0] CR_END_CSR = 19'h000D7;
	// relocation rom window and the function mask bytes in it
	localparam logic [18:0] RELOC_LO   = 19'h00103;
	localparam logic [18:0] RELOC_HI   = 19'h0074F;
	localparam logic [18:0] MASK_OFS   = 19'h00623;
	// user rom and user csr regions
	localparam logic [23:0] ROM_START  = 24'h001003;
	localparam logic [23:0] ROM_END    = 24'h0010FF;
	localparam logic [23:0] CSR_START  = 24'h07FC03;
	localparam logic [23:0] CSR_END    = 24'h07FCFF;
	localparam logic [18:0] RSV_SPAN   = 19'h0003C;
	localparam logic [18:0] USER_OFS   = 19'h00040;
	// status space
	localparam logic [18:0] CSR_BITSET = 19'h7FFFB;
	localparam logic [18:0] CSR_BITCLR = 19'h7FFF7;
	localparam logic [18:0] CMP_OFS    = 19'h7FF63;
	localparam logic [18:0] CMP_LO     = 19'h7FF6F;
	localparam logic [18:0] CMP_HI     = 19'h7FFD3;
	localparam int          BERR_BIT   = 3;
	localparam int          DFS_BIT    = 2;
	localparam int          SIZE_READ_FLAG_BIT   = 1;
	localparam int          CNT_LSB    = 8;
	// capabilities byte fields
	localparam logic        CAP_CNT    = 1'h1;
	localparam logic        CAP_TEST   = 1'h0;
	localparam logic [1:0]  CAP_USER   = 2'h0;
	localparam logic [3:0]  CAP_RSV    = 4'h0;
	// function mask: decode bits plus the dynamic size flag
	localparam logic [31:0] FUNC_MASK  = 32'hFFFF0004;
	localparam logic [31:0] CMP_RST    = 32'h00000000;
	localparam logic [7:0]  STAT_RST   = 8'h00;

	typedef enum logic {UCSR_IDLE, UCSR_ANSWER} ucsr_state_t;

	typedef struct packed {
		logic        strobe;
		logic        write;
		logic [5:0]  am;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} ucsr_req_t;
endpackage

//--- rtl/ucsr_sync.sv
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module ucsr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = d_i;
		sync_d = meta_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q_o = sync_q;
endmodule

//--- rtl/ucsr_top.sv
// config rom / control-status space with variable-length readout
`timescale 1ns/10ps
// Notes on behaviour
// - relocation rom entries live between offsets 0x103 and 0x74F.
// - rom bytes sit at every fourth byte address.
// - a rom byte read returns on the lowest byte lane.
// - multi-byte values are big endian, msb at lowest offset.
// - reserved and unimplemented bits read as zero.
// - user rom: capabilities at start, fifteen zero bytes, then user.
// - capability bit 0 byte count present, bit 1 self test present.
// - capability bits 2,3 user defined; bits 7..4 read zero.
// - user csr: sixteen reserved bytes, user area from start plus 0x40.
// - bit 3 of bit-set and bit-clear is the bus-error-issued flag.
// - compare registers sit between status offsets 0x7FF63 and 0x7FFD3.
// - mask register reports the dynamic size flag, bit 2, set.
// - with size-read flag set, compare bits 31..8 read the byte count.
// - byte count is 24 bits, user defined meaning.
// - compare writes keep decoding; reads return latched count.
// - base bits 7..3 match a23..a19; a18..a0 select the location.
module ucsr_top
	import ucsr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        strobe_i,
	input  wire logic        write_i,
	input  wire logic [5:0]  am_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic [31:0] data_addr_i,
	input  wire logic [4:0]  base_i,
	input  wire logic [23:0] byte_count_i,
	input  wire logic        berr_issued_i,
	output logic      [31:0] rdata_o,
	output logic             ack_o,
	output logic             func_hit_o,
	output logic             berr_flag_o
);
	ucsr_req_t   pin_req;
	ucsr_req_t   req;
	logic [31:0] dsync;
	logic [18:0] ofs;
	logic        sel;

	ucsr_state_t state_q;
	ucsr_state_t state_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        ack_q;
	logic        ack_d;
	logic [7:0]  stat_q;
	logic [7:0]  stat_d;
	logic [31:0] cmp_q;
	logic [31:0] cmp_d;
	logic [23:0] cnt_q;
	logic [23:0] cnt_d;
	logic        hit_q;
	logic        hit_d;

	// picks byte i of a word, byte 0 being the most significant
	function automatic logic [7:0] be_byte(input logic [31:0] v,
			input int i);
		be_byte = v[31-8*i -: 8];
	endfunction

	assign pin_req.strobe = strobe_i;
	assign pin_req.write  = write_i;
	assign pin_req.am     = am_i;
	assign pin_req.addr   = addr_i;
	assign pin_req.wdata  = wdata_i;

	// all bus pins cross in together; the master holds them stable
	// while the strobe is up, so skew between bits settles out
	ucsr_sync #(.W(REQ_W)) u_req_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (pin_req),
		.q_o   (req)
	);

	ucsr_sync #(.W(32)) u_data_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (data_addr_i),
		.q_o   (dsync)
	);

	// low two bits forced so any lane request lands on the rom byte
	assign ofs = {req.addr[18:2], LANE0};
	assign sel = req.strobe && (req.am == AM_CRCSR)
		&& (req.addr[23:19] == base_i);

	always_comb begin
		state_d = state_q;
		rdata_d = rdata_q;
		ack_d   = ack_q;
		stat_d  = stat_q;
		cmp_d   = cmp_q;
		cnt_d   = cnt_q;
		// decode keeps using the written base, never the count
		hit_d = ((dsync ^ cmp_q) & FUNC_MASK & ~32'h000000FF)
			== 32'h00000000;
		// hardware set wins over a software clear in the same cycle
		if (berr_issued_i) begin
			stat_d[BERR_BIT] = 1'b1;
		end
		case (state_q)
			UCSR_IDLE: begin
				ack_d = 1'b0;
				if (sel) begin
					state_d = UCSR_ANSWER;
					ack_d   = 1'b1;
					// upper lanes are free; driven zero
					rdata_d = 32'h00000000;
					if (req.write) begin
						if (ofs == CSR_BITSET) begin
							if (req.wdata[BERR_BIT]) begin
								stat_d[BERR_BIT] = 1'b1;
							end
						end else if (ofs == CSR_BITCLR) begin
							if (req.wdata[BERR_BIT]
									&& !berr_issued_i) begin
								stat_d[BERR_BIT] = 1'b0;
							end
						end else begin
							// separate write path for the base bits
							for (int i = 0; i < 4; i++) begin
								if (ofs == CMP_OFS + 19'(4*i)) begin
									cmp_d[31-8*i -: 8] = req.wdata;
								end
							end
						end
						// rom writes fall through untouched
					end else begin
						for (int i = 0; i < 3; i++) begin
							if (ofs == CR_BEG_ROM + 19'(4*i)) begin
								rdata_d[7:0] = be_byte({8'h00, ROM_START},
									i+1);
							end else if (ofs == CR_END_ROM + 19'(4*i))
									begin
								rdata_d[7:0] = be_byte({8'h00, ROM_END},
									i+1);
							end else if (ofs == CR_BEG_CSR + 19'(4*i))
									begin
								rdata_d[7:0] = be_byte({8'h00, CSR_START},
									i+1);
							end else if (ofs == CR_END_CSR + 19'(4*i))
									begin
								rdata_d[7:0] = be_byte({8'h00, CSR_END},
									i+1);
							end
						end
						if (ofs >= RELOC_LO && ofs <= RELOC_HI) begin
							// rest of the relocation rom reads zero
							for (int i = 0; i < 4; i++) begin
								if (ofs == MASK_OFS + 19'(4*i)) begin
									rdata_d[7:0] = be_byte(FUNC_MASK, i);
								end
							end
						end else if (ofs == ROM_START[18:0]) begin
							rdata_d[7:0] = {CAP_RSV, CAP_USER,
								CAP_TEST, CAP_CNT};
						end else if (ofs > ROM_START[18:0] && ofs
								<= ROM_START[18:0] + RSV_SPAN) begin
							rdata_d[7:0] = 8'h00;
						end else if (ofs >= CSR_START[18:0] && ofs
								<= CSR_START[18:0] + RSV_SPAN) begin
							rdata_d[7:0] = 8'h00;
						end else if (ofs == CSR_BITSET
								|| ofs == CSR_BITCLR) begin
							rdata_d[7:0] = stat_q;
						end else if (ofs >= CMP_OFS && ofs <= CMP_HI)
								begin
							// function 0 starts at the span start, CMP_OFS;
							// functions other than the first read zero
							for (int i = 0; i < 4; i++) begin
								if (ofs == CMP_OFS + 19'(4*i)) begin
									rdata_d[7:0] = be_byte(cmp_q, i);
									if (cmp_q[SIZE_READ_FLAG_BIT] && i < 3) begin
										// msb read latches the count so
										// the three bytes stay coherent
										rdata_d[7:0] = be_byte(
											{(i == 0) ? byte_count_i
											: cnt_q, 8'h00}, i);
									end
								end
							end
							if (ofs == CMP_OFS && cmp_q[SIZE_READ_FLAG_BIT]) begin
								cnt_d = byte_count_i;
							end
						end
						// user areas beyond the fixed bytes read zero
					end
				end
			end
			UCSR_ANSWER: begin
				if (!req.strobe) begin
					state_d = UCSR_IDLE;
					ack_d   = 1'b0;
				end
			end
			default: begin
				state_d = UCSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= UCSR_IDLE;
			rdata_q <= 32'h00000000;
			ack_q   <= 1'b0;
			stat_q  <= STAT_RST;
			cmp_q   <= CMP_RST;
			cnt_q   <= 24'h000000;
			hit_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			rdata_q <= rdata_d;
			ack_q   <= ack_d;
			stat_q  <= stat_d;
			cmp_q   <= cmp_d;
			cnt_q   <= cnt_d;
			hit_q   <= hit_d;
		end
	end

	assign rdata_o     = rdata_q;
	assign ack_o       = ack_q;
	assign func_hit_o  = hit_q;
	assign berr_flag_o = stat_q[BERR_BIT];
endmodule

//--- bench/ucsr_properties.sv
// pin timing and decode checks for the config space readout
`timescale 1ns/10ps
module ucsr_properties
	import ucsr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        strobe_i,
	input  wire logic [5:0]  am_i,
	input  wire logic [23:0] addr_i,
	input  wire logic [4:0]  base_i,
	input  wire logic        berr_issued_i,
	input  wire logic [31:0] rdata_o,
	input  wire logic        ack_o,
	input  wire logic        berr_flag_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	lane_zero_a: assert property (ack_o |-> rdata_o[31:8] == 24'h000000)
		else $error("upper lanes not zero");
	ack_rise_a: assert property ($rose(strobe_i) && am_i == AM_CRCSR &&
		addr_i[23:19] == base_i |-> ##3 $rose(ack_o))
		else $error("selected access not acked in 3");
	ack_cause_a: assert property ($rose(ack_o) |-> $past(strobe_i, 3) &&
		am_i == AM_CRCSR && addr_i[23:19] == base_i)
		else $error("ack without selected access");
	no_sel_a: assert property (
		(strobe_i && addr_i[23:19] != base_i)[*4] |-> !ack_o)
		else $error("ack on other base");
	bad_am_a: assert property ((strobe_i && am_i != AM_CRCSR)[*4] |-> !ack_o)
		else $error("ack on wrong modifier");
	ack_drop_a: assert property ((!strobe_i)[*3] |=> !ack_o)
		else $error("ack held after strobe low");
	berr_set_a: assert property (berr_issued_i |=> berr_flag_o)
		else $error("bus error flag not set");
	berr_keep_a: assert property (
		((!strobe_i)[*3] ##0 !berr_issued_i) |=> $stable(berr_flag_o))
		else $error("bus error flag moved while idle");
endmodule

//--- bench/ucsr_master.sv
// pin-level bus master model for config space access
`timescale 1ns/10ps
module ucsr_master
	import ucsr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] rdata_i,
	output logic             strobe_o,
	output logic             write_o,
	output logic      [5:0]  am_o,
	output logic      [23:0] addr_o,
	output logic      [7:0]  wdata_o
);
	initial
		{strobe_o, write_o, am_o, addr_o, wdata_o} = 40'h0;
	// all pins held until ack is sampled high or eight clocks pass
	task automatic access(input logic w, input logic [5:0] am,
		input logic [23:0] a, input logic [7:0] d,
		output logic [31:0] rd, output bit ok);
		int n;
		@(negedge clk_i);
		{write_o, am_o, addr_o, wdata_o} = {w, am, a, d};
		strobe_o = 1'h1;
		ok = 0;
		for (n = 0; n < 8 && !ok; n++) begin
			@(posedge clk_i);
			ok = (ack_i === 1'h1);
		end
		rd = rdata_i;
		@(negedge clk_i);
		strobe_o = 1'h0;
		// released address and data lines flip so no stale value can pass
		addr_o = ~addr_o;
		wdata_o = ~wdata_o;
		repeat (4) @(negedge clk_i);
	endtask
endmodule

//--- bench/ucsr_top_tb.sv
// self-checking bench for the config space readout
`timescale 1ns/10ps
module ucsr_top_tb;
	import ucsr_pkg::*;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        berr_issued_i = 1'h0;
	logic        strobe_i, write_i, ack_o, func_hit_o, berr_flag_o;
	logic [5:0]  am_i;
	logic [4:0]  base_i;
	logic [7:0]  wdata_i, e;
	logic [23:0] addr_i, byte_count_i;
	logic [31:0] data_addr_i, rdata_o, rd, v;
	int          error_cnt = 0, checks_done = 0, i, cmp_m, got, rq;
	int          seed = 32'h7ED08E21;
	bit          ok;
	ucsr_top uut (.clk_i, .rst_i, .strobe_i, .write_i, .am_i, .addr_i,
		.wdata_i, .data_addr_i, .base_i, .byte_count_i, .berr_issued_i,
		.rdata_o, .ack_o, .func_hit_o, .berr_flag_o);
	ucsr_master m (.clk_i, .ack_i(ack_o), .rdata_i(rdata_o),
		.strobe_o(strobe_i), .write_o(write_i), .am_o(am_i),
		.addr_o(addr_i), .wdata_o(wdata_i));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [18:0] o, input logic [7:0] d);
		m.access(w, AM_CRCSR, {base_i, o}, d, rd, ok);
		if (!ok) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
			tally_and_finish();
		end
	endtask
	task automatic rdc(input logic [18:0] o, input logic [7:0] x);
		acc(1'h0, o, 8'h00);
		chk(rd, {24'h000000, x});
	endtask
	// decode follows the last written base, count reads aside
	task automatic hit();
		int k;
		for (k = 0; k < 4; k++) begin
			data_addr_i = $random(seed);
			if (k % 2)
				data_addr_i[31:16] = cmp_m[31:16];
			repeat (4) @(negedge clk_i);
			chk(func_hit_o, ((data_addr_i ^ cmp_m) & 32'hFFFF0000) == 0);
		end
	endtask
	initial
		forever #20 clk_i = ~clk_i;
	initial begin
		#400000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		base_i = 5'($random(seed));
		data_addr_i = 32'h00000000;
		byte_count_i = 24'h000000;
		repeat (12) @(negedge clk_i);
		rst_i = 1'h0;
		for (i = 0; i < 12; i++) begin
			v = i < 3 ? ROM_START : i < 6 ? ROM_END : i < 9 ? CSR_START : CSR_END;
			e = 8'(v >> 8 * (2 - i % 3));
			rdc(CR_BEG_ROM + 19'(4 * i), e);
		end
		$display("pointers done");
		acc(1'h1, ROM_START[18:0], 8'hFF);
		for (i = 0; i <= 16; i++) begin
			e = i ? 8'h00 : 8'h01;
			rdc(ROM_START[18:0] + 19'(4 * i), e);
			rdc(CSR_START[18:0] + 19'(4 * i), 8'h00);
		end
		for (i = 0; i < 4; i++)
			rdc(MASK_OFS + 19'(4 * i), 8'(FUNC_MASK >> 8 * (3 - i)));
		chk(rd[DFS_BIT], 1'h1);
		$display("rom and status space done");
		cmp_m = $random(seed) | 2;
		for (i = 0; i < 4; i++)
			acc(1'h1, CMP_OFS + 19'(4 * i), 8'(cmp_m >> 8 * (3 - i)));
		hit();
		byte_count_i = 24'($random(seed));
		// count read ahead of any readout
		got = 0;
		for (i = 0; i < 4; i++) begin
			e = 8'(i == 3 ? cmp_m : byte_count_i >> 8 * (2 - i));
			rdc(CMP_OFS + 19'(4 * i), e);
			if (i < 3)
				got = (got << 8) | rd[7:0];
		end
		// a 64-bit block never asks beyond 2K bytes
		rq = got > 2048 ? 2048 : got;
		chk(got, byte_count_i);
		chk(rq, byte_count_i > 2048 ? 2048 : byte_count_i);
		hit();
		cmp_m = cmp_m & ~2;
		acc(1'h1, CMP_OFS + 19'h0000C, 8'(cmp_m));
		rdc(CMP_OFS, 8'(cmp_m >> 24));
		$display("byte count done");
		@(negedge clk_i);
		berr_issued_i = 1'h1;
		@(negedge clk_i);
		berr_issued_i = 1'h0;
		chk(berr_flag_o, 1'h1);
		rdc(CSR_BITSET, 8'h08);
		acc(1'h1, CSR_BITCLR, 8'h08);
		rdc(CSR_BITCLR, 8'h00);
		acc(1'h1, CSR_BITSET, 8'h08);
		chk(berr_flag_o, 1'h1);
		$display("bus error flag done");
		m.access(1'h0, AM_CRCSR, {~base_i, 19'h000B3}, 8'h00, rd, ok);
		chk(ok, 1'h0);
		m.access(1'h0, 6'h2E, {base_i, 19'h000B3}, 8'h00, rd, ok);
		chk(ok, 1'h0);
		$display("refusals done");
		tally_and_finish();
	end
endmodule
bind ucsr_top ucsr_properties chk_u (.clk_i, .rst_i, .strobe_i, .am_i,
	.addr_i, .base_i, .berr_issued_i, .rdata_o, .ack_o, .berr_flag_o);
